// file: design/cam_defs.svh
// constants of the core addressing block: offsets, field positions, reset values and opcode patterns
`ifndef CAM_DEFS_SVH
`define CAM_DEFS_SVH

`define CAM_PC_W          21
`define CAM_PC_RESET      21'h000000
`define CAM_PC_STEP       21'h000002
`define CAM_NOP_WORD      16'h0000
`define CAM_SECOND_TAG    4'hf
`define CAM_BANK_RESET    8'h00
`define CAM_BANK_ADDR     12'hfe0
`define CAM_SPECIAL_BASE  12'hf38
`define CAM_ACCESS_SPLIT  8'h60
`define CAM_ACCESS_LO     4'h0
`define CAM_ACCESS_HI     4'hf
`define CAM_A_BIT         8
`define CAM_D_BIT         9
`define CAM_OP_LOAD_BANK  12'h010
`define CAM_OP_MOVLW      8'h0e
`define CAM_OP_GOTO       8'hef
`define CAM_OP_CALL       7'h76
`define CAM_OP_LFSR       10'h3b8
`define CAM_OP_BRA        5'h1a
`define CAM_OP_MOVE_FULL  4'hc
`define CAM_OP_MOVF       6'h14
`define CAM_OP_MOVWF      7'h37
`define CAM_OP_TSTFSZ     7'h33

`endif

// file: design/cam_pkg.sv
// types shared by the core addressing block
package cam_pkg;

   typedef enum logic [1:0]
   {
      PH_ONE   = 2'b00,
      PH_TWO   = 2'b01,
      PH_THREE = 2'b10,
      PH_FOUR  = 2'b11
   } cam_phase_e;

   typedef enum logic [3:0]
   {
      OP_NOP       = 4'b0000,
      OP_LOAD_BANK = 4'b0001,
      OP_MOVLW     = 4'b0010,
      OP_GOTO      = 4'b0011,
      OP_CALL      = 4'b0100,
      OP_LFSR      = 4'b0101,
      OP_BRA       = 4'b0110,
      OP_MOVE_FULL = 4'b0111,
      OP_MOVF      = 4'b1000,
      OP_MOVWF     = 4'b1001,
      OP_TSTFSZ    = 4'b1010
   } cam_op_e;

   typedef struct packed
   {
      logic        we;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } cam_ram_req_s;

   typedef struct packed
   {
      logic        load;
      logic [1:0]  sel;
      logic [11:0] value;
   } cam_ptr_s;

endpackage

// file: design/cam_ram.sv
// data ram of the core with a registered read port
`timescale 1ns/10ps
module cam_ram
#(
   parameter int AW = 12,
   parameter int DW = 8
)
(
   // clock
   input  wire logic          clk,
   // access
   input  wire logic          re,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rd_data
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // contents are not initialised, as general ram is not cleared by reset
   always_ff @(posedge clk)
   begin
      if (we)
         mem[addr] <= wdata;
   end

   always_ff @(posedge clk)
   begin
      if (re)
         rd_data <= mem[addr];
   end

endmodule

// file: design/cam_core_addr.sv
// core addressing: phase sequencing, program counter, two-word handling and data address formation
// How it works
// RULE1 - program memory is byte addressed; instruction words sit at even addresses
// RULE2 - pc steps by two per word; its lowest bit is always zero
// RULE3 - call and jump load their embedded word address into pc bits 20..1
// RULE4 - relative branch offset counts single words, applied in word units
// RULE5 - second words of two-word instructions start with 1111, twelve literal bits follow
// RULE6 - a second word executed right after its first supplies its literal
// RULE7 - a 1111 word executed without its first word acts as a no-operation
// RULE8 - data addresses are 12 bits: sixteen banks of 256 bytes
// RULE9 - reads of unimplemented data locations return zero
// RULE10 - banked address is bank pointer low nibble above the 8-bit operand
// RULE11 - only bank pointer bits 3..0 exist; upper bits read zero, ignore writes
// RULE12 - load-bank-literal writes its literal straight into the bank pointer
// RULE13 - unimplemented banks drop writes, read zero, flags still update
// RULE14 - full-address move takes both 12-bit addresses, ignoring the bank pointer
// RULE15 - access bank: 00h-5Fh to bank 0 bottom, 60h-FFh to bank 15 top
// RULE16 - select bit one uses bank pointer, zero uses access bank mapping
// RULE17 - access bank operands reach their target in one instruction cycle
// RULE18 - extended set enable switches to an alternative access mapping; here the low access window only reads zero and drops writes
// RULE19 - four phases per instruction cycle; next fetch overlaps current execute
// RULE20 - operand read in phase two, destination write in phase four
// RULE21 - instructions that change pc take two cycles; fetched word is flushed
// RULE22 - special registers occupy F38h to FFFh in bank 15
// RULE23 - a two-word instruction in sequence takes two instruction cycles
// RULE24 - bank pointer is zero after reset
`timescale 1ns/10ps
`include "cam_defs.svh"
module cam_core_addr
#(
   parameter logic [15:0] IMPL_BANKS = 16'h800f
)
(
   // clock and reset
   input  wire logic        CLOCK,
   input  wire logic        NRST,
   // program memory
   output logic [20:0]      PROG_ADDR,
   input  wire logic [15:0] PROG_DATA,
   // configuration
   input  wire logic        EXT_SET_EN,
   // core state
   output logic [1:0]       PHASE,
   output logic [7:0]       BANK_POINTER,
   output logic [7:0]       WREG,
   output logic             ZERO_FLAG,
   // data write observation
   output logic [11:0]      DATA_ADDR,
   output logic             DATA_WR,
   // pointer load
   output logic             PTR_LOAD,
   output logic [1:0]       PTR_SEL,
   output logic [11:0]      PTR_VALUE
);

   cam_pkg::cam_phase_e   phase_q;
   cam_pkg::cam_op_e      op;
   cam_pkg::cam_op_e      first_op;
   cam_pkg::cam_ram_req_s ram_req;
   cam_pkg::cam_ptr_s     ptr_q;
   logic [20:0]           pc_q;
   logic [20:0]           prog_addr_q;
   logic [20:0]           jump_target;
   logic [20:0]           bra_target;
   logic [15:0]           ir_q;
   logic [15:0]           first_q;
   logic                  second_q;
   logic                  sec_word;
   logic [7:0]            bank_q;
   logic [7:0]            w_q;
   logic                  zero_q;
   logic [7:0]            opnd_q;
   logic [7:0]            rd_data;
   logic                  src_ok_q;
   logic                  src_bank_q;
   logic [11:0]           f_addr;
   logic [11:0]           wr_addr;
   logic [7:0]            wr_data;
   logic                  ext_meta_q;
   logic                  ext_q;
   logic                  hole;
   logic                  rd_req;
   logic                  wr_req;
   logic                  bank_hit;
   logic                  take_jump;
   logic                  take_bra;
   logic                  skip;
   logic                  flush;
   logic [11:0]           data_addr_q;
   logic                  data_wr_q;

   function automatic cam_pkg::cam_op_e decode(input logic [15:0] w);
      decode = cam_pkg::OP_NOP;
      if (w[15:4] == `CAM_OP_LOAD_BANK)
         decode = cam_pkg::OP_LOAD_BANK;
      else if (w[15:8] == `CAM_OP_MOVLW)
         decode = cam_pkg::OP_MOVLW;
      else if (w[15:8] == `CAM_OP_GOTO)
         decode = cam_pkg::OP_GOTO;
      else if (w[15:9] == `CAM_OP_CALL)
         decode = cam_pkg::OP_CALL;
      else if (w[15:6] == `CAM_OP_LFSR)
         decode = cam_pkg::OP_LFSR;
      else if (w[15:11] == `CAM_OP_BRA)
         decode = cam_pkg::OP_BRA;
      else if (w[15:12] == `CAM_OP_MOVE_FULL)
         decode = cam_pkg::OP_MOVE_FULL;
      else if (w[15:10] == `CAM_OP_MOVF)
         decode = cam_pkg::OP_MOVF;
      else if (w[15:9] == `CAM_OP_MOVWF)
         decode = cam_pkg::OP_MOVWF;
      else if (w[15:9] == `CAM_OP_TSTFSZ)
         decode = cam_pkg::OP_TSTFSZ;
   endfunction

   // special registers always answer, whatever the bank mask says
   function automatic logic implemented(input logic [11:0] a);
      implemented = IMPL_BANKS[a[11:8]] || (a >= `CAM_SPECIAL_BASE); // RULE22
   endfunction

   // configuration pin comes from outside the core clock
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         ext_meta_q <= 1'b0;
         ext_q      <= 1'b0;
      end
      else
      begin
         ext_meta_q <= EXT_SET_EN;
         ext_q      <= ext_meta_q;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
         phase_q <= cam_pkg::PH_ONE;
      else
         phase_q <= cam_pkg::cam_phase_e'(phase_q + 2'h1); // RULE19
   end

   always_comb
   begin
      first_op = decode(first_q);
      // a 1111 word only does work when it follows its own first word
      op       = second_q ? cam_pkg::OP_NOP : decode(ir_q); // RULE7
      sec_word = second_q && (ir_q[15:12] == `CAM_SECOND_TAG); // RULE5 RULE6
   end

   always_comb
   begin
      if (op == cam_pkg::OP_MOVE_FULL)
         f_addr = ir_q[11:0]; // RULE14
      else if (ir_q[`CAM_A_BIT])
         f_addr = {bank_q[3:0], ir_q[7:0]}; // RULE10 RULE16
      else if (ir_q[7:0] < `CAM_ACCESS_SPLIT)
         f_addr = {`CAM_ACCESS_LO, ir_q[7:0]}; // RULE15 RULE17
      else
         f_addr = {`CAM_ACCESS_HI, ir_q[7:0]}; // RULE15
   end

   // the extended access map is not provided here: its low window reads zero and drops writes;
   // a second word carries a full address, so its low bits are never an access-bank operand
   assign hole     = ext_q && (op != cam_pkg::OP_MOVE_FULL) && !sec_word && !ir_q[`CAM_A_BIT]
                     && (ir_q[7:0] < `CAM_ACCESS_SPLIT); // RULE18
   assign wr_addr  = sec_word ? ir_q[11:0] : f_addr; // RULE14
   assign wr_data  = (op == cam_pkg::OP_MOVWF) ? w_q : opnd_q;
   assign rd_req   = (phase_q == cam_pkg::PH_TWO) && ((op == cam_pkg::OP_MOVF) || (op == cam_pkg::OP_TSTFSZ)
                     || (op == cam_pkg::OP_MOVE_FULL)); // RULE20
   assign wr_req   = (phase_q == cam_pkg::PH_FOUR) && !hole
                     && ((sec_word && (first_op == cam_pkg::OP_MOVE_FULL)) || (op == cam_pkg::OP_MOVWF)
                     || ((op == cam_pkg::OP_MOVF) && ir_q[`CAM_D_BIT])); // RULE20 RULE6
   assign bank_hit = (wr_addr == `CAM_BANK_ADDR);

   always_comb
   begin
      ram_req.we    = wr_req && !bank_hit && implemented(wr_addr); // RULE13
      ram_req.addr  = (phase_q == cam_pkg::PH_FOUR) ? wr_addr : f_addr; // RULE8
      ram_req.wdata = wr_data;
   end

   cam_ram #(
      .AW (12),
      .DW (8)
   ) u_ram (
      .clk     (CLOCK),
      .re      (rd_req),
      .we      (ram_req.we),
      .addr    (ram_req.addr),
      .wdata   (ram_req.wdata),
      .rd_data (rd_data)
   );

   // operand path: locate in phase two, capture in phase three
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         src_ok_q   <= 1'b0;
         src_bank_q <= 1'b0;
         opnd_q     <= 8'h00;
      end
      else if (phase_q == cam_pkg::PH_TWO)
      begin
         src_ok_q   <= implemented(f_addr) && !hole;
         src_bank_q <= (f_addr == `CAM_BANK_ADDR);
      end
      else if ((phase_q == cam_pkg::PH_THREE) && (op != cam_pkg::OP_NOP))
      begin
         if (src_bank_q)
            opnd_q <= bank_q; // RULE11
         else
            opnd_q <= src_ok_q ? rd_data : 8'h00; // RULE9 RULE13
      end
   end

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
         bank_q <= `CAM_BANK_RESET; // RULE24
      else if ((phase_q == cam_pkg::PH_FOUR) && (op == cam_pkg::OP_LOAD_BANK))
         bank_q <= {4'h0, ir_q[3:0]}; // RULE12 RULE11
      else if (wr_req && bank_hit)
         bank_q <= {4'h0, wr_data[3:0]}; // RULE11
   end

   // status and working register move even when the location is missing
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         w_q    <= 8'h00;
         zero_q <= 1'b0;
      end
      else if (phase_q == cam_pkg::PH_FOUR)
      begin
         if (op == cam_pkg::OP_MOVLW)
            w_q <= ir_q[7:0];
         else if (op == cam_pkg::OP_MOVF)
         begin
            zero_q <= (opnd_q == 8'h00); // RULE13
            if (!ir_q[`CAM_D_BIT])
               w_q <= opnd_q;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         data_addr_q <= 12'h000;
         data_wr_q   <= 1'b0;
      end
      else
      begin
         data_wr_q <= wr_req;
         if (wr_req)
            data_addr_q <= wr_addr;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
         ptr_q <= '0;
      else
      begin
         ptr_q.load <= (phase_q == cam_pkg::PH_FOUR) && sec_word && (first_op == cam_pkg::OP_LFSR); // RULE6
         if ((phase_q == cam_pkg::PH_FOUR) && sec_word && (first_op == cam_pkg::OP_LFSR))
         begin
            ptr_q.sel   <= first_q[5:4];
            ptr_q.value <= {first_q[3:0], ir_q[7:0]};
         end
      end
   end

   // call and jump read their second word straight off the fetch bus, so they need no third cycle
   assign jump_target = {PROG_DATA[11:0], ir_q[7:0], 1'b0}; // RULE3
   // pc already points one word past the fetched word; back off one word first
   assign bra_target  = pc_q - `CAM_PC_STEP + {{9{ir_q[10]}}, ir_q[10:0], 1'b0}; // RULE4
   assign take_jump   = (op == cam_pkg::OP_GOTO) || (op == cam_pkg::OP_CALL);
   assign take_bra    = (op == cam_pkg::OP_BRA);
   assign skip        = (op == cam_pkg::OP_TSTFSZ) && (opnd_q == 8'h00);
   assign flush       = take_jump || take_bra || skip; // RULE21

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         pc_q        <= `CAM_PC_RESET;
         prog_addr_q <= `CAM_PC_RESET;
      end
      else if (phase_q == cam_pkg::PH_ONE)
      begin
         prog_addr_q <= pc_q; // RULE1
         pc_q        <= pc_q + `CAM_PC_STEP; // RULE2
      end
      else if ((phase_q == cam_pkg::PH_FOUR) && take_jump)
         pc_q <= jump_target; // RULE3
      else if ((phase_q == cam_pkg::PH_FOUR) && take_bra)
         pc_q <= bra_target; // RULE4
   end

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         ir_q     <= `CAM_NOP_WORD;
         first_q  <= `CAM_NOP_WORD;
         second_q <= 1'b0;
      end
      else if (phase_q == cam_pkg::PH_FOUR)
      begin
         ir_q     <= flush ? `CAM_NOP_WORD : PROG_DATA; // RULE19 RULE21
         second_q <= !flush && ((op == cam_pkg::OP_MOVE_FULL) || (op == cam_pkg::OP_LFSR)); // RULE23
         first_q  <= ir_q;
      end
   end

   assign PROG_ADDR    = prog_addr_q;
   assign PHASE        = phase_q;
   assign BANK_POINTER = bank_q;
   assign WREG         = w_q;
   assign ZERO_FLAG    = zero_q;
   assign DATA_ADDR    = data_addr_q;
   assign DATA_WR      = data_wr_q;
   assign PTR_LOAD     = ptr_q.load;
   assign PTR_SEL      = ptr_q.sel;
   assign PTR_VALUE    = ptr_q.value;

   a_pc_even: assert property (@(posedge CLOCK) disable iff (!NRST) !pc_q[0] && !prog_addr_q[0]) // RULE1
      else $error("pc lowest bit set");
   a_pc_step: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE2
      (phase_q == cam_pkg::PH_ONE) |=> (pc_q == $past(pc_q) + `CAM_PC_STEP))
      else $error("pc did not step by two");
   a_jump_load: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE3
      ((phase_q == cam_pkg::PH_FOUR) && take_jump) |=> (pc_q == {$past(PROG_DATA[11:0]), $past(ir_q[7:0]), 1'b0}))
      else $error("jump target wrong");
   // while a branch executes, the fetch address already names the word after it: the offset's base
   a_bra_offset: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE4
      ((phase_q == cam_pkg::PH_FOUR) && take_bra)
      |=> (pc_q == $past(prog_addr_q) + {{9{$past(ir_q[10])}}, $past(ir_q[10:0]), 1'b0}) ##1 (ir_q == `CAM_NOP_WORD))
      else $error("branch target or flush wrong");
   a_stray_second: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE7
      (!second_q && (ir_q[15:12] == `CAM_SECOND_TAG)) |-> (op == cam_pkg::OP_NOP) && !wr_req && !flush)
      else $error("stray second word did work");
   a_bank_upper: assert property (@(posedge CLOCK) disable iff (!NRST) bank_q[7:4] == 4'h0) // RULE11
      else $error("bank pointer upper bits set");
   a_bank_load: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE12
      ((phase_q == cam_pkg::PH_FOUR) && (op == cam_pkg::OP_LOAD_BANK))
      |=> (BANK_POINTER == {4'h0, $past(ir_q[3:0])}))
      else $error("bank literal not loaded");
   a_access_map: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE15 RULE16
      ((op != cam_pkg::OP_MOVE_FULL) && !ir_q[`CAM_A_BIT]) |-> (f_addr[11:8] == ((ir_q[7:0] < `CAM_ACCESS_SPLIT)
      ? `CAM_ACCESS_LO : `CAM_ACCESS_HI)))
      else $error("access bank mapping wrong");
   a_unimpl_zero: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE9
      ((phase_q == cam_pkg::PH_THREE) && (op != cam_pkg::OP_NOP) && !src_ok_q && !src_bank_q) |=> (opnd_q == 8'h00))
      else $error("unimplemented read not zero");
   a_write_phase: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE20
      DATA_WR |-> ($past(phase_q) == cam_pkg::PH_FOUR) && (phase_q == cam_pkg::PH_ONE))
      else $error("write outside phase four");
   // the destination is the second word as it stood on the fetch bus a cycle earlier
   a_full_move_dest: assert property (@(posedge CLOCK) disable iff (!NRST) // RULE14 RULE23
      ((phase_q == cam_pkg::PH_FOUR) && (op == cam_pkg::OP_MOVE_FULL)) ##4 wr_req
      |-> (wr_addr == $past(PROG_DATA[11:0], 4)))
      else $error("full move destination wrong");

endmodule

// file: testbench/cam_prog_mem.sv
// behavioural program memory standing behind the fetch port of the addressing block
`timescale 1ns/10ps
module cam_prog_mem
(
   // program image held by the bench
   input  wire logic [15:0] image [128],
   // fetch port
   input  wire logic [20:0] prog_addr,
   output logic      [15:0] prog_data
);
   // bytes pair into words, low byte at the even address, so bit 0 never selects
   always_comb
   begin
      if (prog_addr[20:8] == 13'h0000)
      begin
         prog_data = image[prog_addr[7:1]];
      end
      else
      begin
         // beyond the small image: a stray second-word pattern, never a useful opcode
         prog_data = 16'hffff;
      end
   end
endmodule

// file: testbench/core_memory_addressing_bench.sv
// self-checking bench of the core addressing block driving programs through the fetch port
`timescale 1ns/10ps
`include "cam_defs.svh"
module core_memory_addressing_bench;
   typedef logic [20:0] cam_val_t;

   logic        CLOCK = 1'b0;
   logic        NRST = 1'b0;
   logic        EXT_SET_EN = 1'b0;
   logic [20:0] PROG_ADDR;
   logic [15:0] PROG_DATA;
   logic [1:0]  PHASE;
   logic [7:0]  BANK_POINTER;
   logic [7:0]  WREG;
   logic        ZERO_FLAG;
   logic [11:0] DATA_ADDR;
   logic        DATA_WR;
   logic        PTR_LOAD;
   logic [1:0]  PTR_SEL;
   logic [11:0] PTR_VALUE;
   logic [15:0] image [128];
   cam_val_t    fetch_q[$];
   cam_val_t    wr_q[$];
   cam_val_t    w_q[$];
   logic [7:0]  w_prev = 8'h00;
   logic [1:0]  ph_prev = 2'h0;
   int          ptr_loads = 0;
   int          miscompares = 0;
   int          num_checks = 0;

   cam_core_addr #(.IMPL_BANKS(16'h800f)) u_dut
   (
      .CLOCK        (CLOCK),
      .NRST         (NRST),
      .PROG_ADDR    (PROG_ADDR),
      .PROG_DATA    (PROG_DATA),
      .EXT_SET_EN   (EXT_SET_EN),
      .PHASE        (PHASE),
      .BANK_POINTER (BANK_POINTER),
      .WREG         (WREG),
      .ZERO_FLAG    (ZERO_FLAG),
      .DATA_ADDR    (DATA_ADDR),
      .DATA_WR      (DATA_WR),
      .PTR_LOAD     (PTR_LOAD),
      .PTR_SEL      (PTR_SEL),
      .PTR_VALUE    (PTR_VALUE)
   );

   cam_prog_mem u_prog
   (
      .image     (image),
      .prog_addr (PROG_ADDR),
      .prog_data (PROG_DATA)
   );

   always #25 CLOCK = ~CLOCK;

   task automatic chk(input string name, input cam_val_t exp, input cam_val_t got);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // compares the leading entries only: looping programs keep adding fetches
   task automatic cmp_q(input string name, input cam_val_t exp[$], input cam_val_t got[$]);
      chk({name, " count"}, 21'h000001, 21'(exp.size() <= got.size()));
      for (int i = 0; i < exp.size() && i < got.size(); i++)
      begin
         chk($sformatf("%s %0d", name, i), exp[i], got[i]);
      end
   endtask

   // samples one settled nanosecond after each rising edge
   always @(posedge CLOCK)
   begin
      #1;
      if (NRST === 1'b1)
      begin
         chk("phase step", 21'(2'(ph_prev + 2'h1)), 21'(PHASE));
         if (PHASE === 2'h1)
         begin
            fetch_q.push_back(PROG_ADDR);
         end
         if (DATA_WR === 1'b1)
         begin
            wr_q.push_back(21'(DATA_ADDR));
            chk("write phase", 21'h000000, 21'(PHASE));
         end
         if (WREG !== w_prev)
         begin
            w_q.push_back(21'(WREG));
         end
         if (PTR_LOAD === 1'b1)
         begin
            ptr_loads++;
         end
      end
      w_prev = WREG;
      ph_prev = PHASE;
   end

   task automatic prog(input int at, input logic [15:0] w[$]);
      if (at == 0)
      begin
         for (int i = 0; i < 128; i++)
         begin
            image[i] = `CAM_NOP_WORD;
         end
      end
      foreach (w[i])
      begin
         image[at + i] = w[i];
      end
   endtask

   task automatic run(input int n);
      @(posedge CLOCK);
      #2;
      NRST = 1'b0;
      fetch_q.delete();
      wr_q.delete();
      w_q.delete();
      ptr_loads = 0;
      repeat (2) @(posedge CLOCK);
      #2;
      chk("bank after reset", 21'h000000, 21'(BANK_POINTER));
      NRST = 1'b1;
      repeat (n) @(posedge CLOCK);
      #2;
   endtask

   // jump, call and a one-word backward branch; flushed fetches show in the fetch trail
   task automatic sc_branch;
      prog(0, '{16'hef08, 16'hf000});
      prog(8, '{16'h0e55, 16'hec10, 16'hf000});
      prog(16, '{16'hd7ff});
      run(60);
      cmp_q("fetch", '{21'h0, 21'h2, 21'h10, 21'h12, 21'h14, 21'h20, 21'h22, 21'h20, 21'h22, 21'h20},
            fetch_q);
      chk("wreg", 21'h000055, 21'(WREG));
   endtask

   // bank pointer written as a register, by literal, and bypassed through the access bank
   task automatic sc_banked;
      prog(0, '{16'h0ef3, 16'h6ee0, 16'h6f20, 16'h0102, 16'h6f20, 16'h6e20, 16'h6e70, 16'hd7ff});
      run(80);
      cmp_q("write addr", '{21'hfe0, 21'h320, 21'h220, 21'h020, 21'hf70},
            wr_q);
      chk("bank pointer", 21'h000002, 21'(BANK_POINTER));
   endtask

   // bank 5 is not built: its write drops, its read gives zero and still sets the flag
   task automatic sc_unimpl;
      prog(0, '{16'h0e77, 16'h6e20, 16'h0105, 16'h6f40, 16'hc020, 16'hf130, 16'h0101, 16'h0e11,
                16'h5130, 16'h0105, 16'h5140, 16'hd7ff});
      run(100);
      cmp_q("write addr", '{21'h020, 21'h540, 21'h130}, wr_q);
      cmp_q("wreg trail", '{21'h77, 21'h11, 21'h77, 21'h00}, w_q);
      chk("zero flag", 21'h000001, 21'(ZERO_FLAG));
   endtask

   // a taken skip leaves a lone second word that must do nothing
   task automatic sc_skip;
      prog(0, '{16'h0e00, 16'h6e20, 16'h6620, 16'hc020, 16'hf130, 16'h0e42, 16'h6e21, 16'h6621,
                16'hc021, 16'hf131, 16'hee1a, 16'hf0bc, 16'hd7ff});
      run(120);
      cmp_q("write addr", '{21'h020, 21'h021, 21'h131}, wr_q);
      cmp_q("wreg trail", '{21'h42}, w_q);
      chk("pointer loads", 21'h000001, 21'(ptr_loads));
      chk("pointer sel", 21'h000001, 21'(PTR_SEL));
      chk("pointer value", 21'h000abc, 21'(PTR_VALUE));
   endtask

   // extended set: the low access window drops writes and reads zero; banked and full moves still reach it
   task automatic sc_extended;
      EXT_SET_EN = 1'b1;
      prog(0, '{16'h0e99, 16'h6f20, 16'h0e55, 16'h6e20, 16'h5020, 16'h5120, 16'hc020, 16'hf021,
                16'h0e00, 16'h5121, 16'hd7ff});
      run(80);
      cmp_q("write addr", '{21'h020, 21'h021}, wr_q);
      cmp_q("wreg trail", '{21'h99, 21'h55, 21'h00, 21'h99, 21'h00, 21'h99}, w_q);
   endtask

   task automatic end_sim;
      if (miscompares == 0 && num_checks > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial
   begin
      sc_branch();
      sc_banked();
      sc_unimpl();
      sc_skip();
      sc_extended();
      end_sim();
   end

   // the five programs need under 500 clocks; allow ample margin
   initial
   begin
      #(1000 * 50);
      miscompares++;
      end_sim();
   end
endmodule
